// ---- hdl/tbps_map.svh ----
// Constants of the two-phase buck steering core
// Contract
// - The four-bit voltage-select code maps to 1.30 V at all ones, rising 50 mV per decrement up to 2.05 V at all zeros.
// - The timing ramp runs from 0 V to 3 V and each arrival at the top raises one cycle event that sets the selected phase.
// - The first cycle event in normal operation drives phase one high.
// - An active phase output goes low at the latest three clocks after the shared current comparator trips, past the two-flop synchroniser.
// - Each successive cycle event hands the drive to the other phase, alternating except that phase one leads again after a halt.
// - Each phase output switches at half the cycle event rate.
// - A phase on-time ends at the latest at the next cycle event, so its duty stays at or below 50 percent.
// - The two phase outputs are never high together.
// - One current comparator serves both phases and acts on whichever phase is active.
// - Feedback below the foldback trigger level selects the lower foldback sense threshold instead of the limit threshold.
// - With the output at zero volts the cycle event rate drops to one fifth.
// - The in-range output is released while feedback is within the window around the target and pulled low otherwise.
// - A crowbar trip forces both phases low until the output falls below the reset level, then operation resumes.
// - A compensation node below 0.56 V stops the oscillator and holds both phases low.
// - An unconnected voltage-select input reads as one.
`ifndef TBPS_MAP_SVH
`define TBPS_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TBPS_CLK_PERIOD_NS  50
`define TBPS_OSC_PERIOD_NS  2500
`define TBPS_OSC_CYCLES     (`TBPS_OSC_PERIOD_NS / `TBPS_CLK_PERIOD_NS)
`define TBPS_FOLD_RATE_DIV  3'h5

// ----------------------------------------------------------------
// Voltage levels in millivolts
// ----------------------------------------------------------------
`define TBPS_RAMP_LOW_MV    12'h000
`define TBPS_RAMP_HIGH_MV   12'hbb8
`define TBPS_TARGET_BASE_MV 12'h514
`define TBPS_TARGET_STEP_MV 12'h032
`define TBPS_FOLD_TRIG_MV   12'h258
`define TBPS_ZERO_MV        12'h032

// ----------------------------------------------------------------
// Window percentages of target
// ----------------------------------------------------------------
`define TBPS_PG_LOW_PCT     8'h58
`define TBPS_PG_HIGH_PCT    8'h7c
`define TBPS_CROW_TRIP_PCT  8'h82
`define TBPS_CROW_RST_PCT   8'h64

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TBPS_SYNC_RST       6'h0f

`endif

// ---- hdl/tbps_pkg.sv ----
// Types shared by the steering core modules
package tbps_pkg;
  // Millivolt quantity
  typedef logic [11:0] tbps_mv_t;

  // Phase steering states, one-hot
  typedef enum logic [4:0] {
    ST_WAIT1 = 5'h01,
    ST_ON1   = 5'h02,
    ST_WAIT2 = 5'h04,
    ST_ON2   = 5'h08,
    ST_HALT  = 5'h10
  } tbps_state_t;
endpackage

// ---- hdl/tbps_ctl_if.sv ----
// Signals between the core, its oscillator and its output monitor
interface tbps_ctl_if;
  logic             run;
  logic             slow;
  logic             cycle_evt;
  tbps_pkg::tbps_mv_t ramp_mv;
  tbps_pkg::tbps_mv_t target_mv;
  tbps_pkg::tbps_mv_t fb_mv;
  logic             in_range;
  logic             crowbar;

  modport osc  (input run, slow, output cycle_evt, ramp_mv);
  modport mon  (input target_mv, fb_mv, output in_range, crowbar);
  modport core (output run, slow, target_mv, fb_mv,
                input cycle_evt, ramp_mv, in_range, crowbar);
endinterface // tbps_ctl_if

// ---- hdl/tbps_osc.sv ----
// Digital timing ramp and cycle event generator
`include "tbps_map.svh"
module tbps_osc #(
  parameter int unsigned OSC_CYCLES = `TBPS_OSC_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control link
  tbps_ctl_if.osc   ctl
);
  localparam logic [11:0] STEP_MV =
    12'((`TBPS_RAMP_HIGH_MV - `TBPS_RAMP_LOW_MV) / OSC_CYCLES);

  logic [2:0]  div_r;
  logic [11:0] ramp_r;
  logic        evt_r;

  // Step enable: every clock, or every fifth in short circuit
  wire         div_last = (div_r == `TBPS_FOLD_RATE_DIV - 3'h1);
  wire         step_en  = ctl.run && (!ctl.slow || div_last);
  wire  [11:0] ramp_add = ramp_r + STEP_MV;
  wire         at_top   = (ramp_add >= `TBPS_RAMP_HIGH_MV);

  // Rate divider
  always_ff @(posedge clk) begin
    if (rst || !ctl.run || !ctl.slow || div_last)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end

  // Ramp 0 V to 3 V, event at the top, stopped when not running
  always_ff @(posedge clk) begin
    if (rst || !ctl.run) begin
      ramp_r <= `TBPS_RAMP_LOW_MV;
      evt_r  <= 1'b0;
    end else begin
      evt_r  <= step_en && at_top;
      if (step_en)
        ramp_r <= at_top ? `TBPS_RAMP_LOW_MV : ramp_add;
    end
  end

  assign ctl.cycle_evt = evt_r;
  assign ctl.ramp_mv   = ramp_r;
endmodule // tbps_osc

// ---- hdl/tbps_mon.sv ----
// Output window monitor and crowbar latch
`include "tbps_map.svh"
module tbps_mon #(
  parameter logic [7:0] PG_LOW_PCT   = `TBPS_PG_LOW_PCT,
  parameter logic [7:0] PG_HIGH_PCT  = `TBPS_PG_HIGH_PCT,
  parameter logic [7:0] CROW_TRIP_PCT = `TBPS_CROW_TRIP_PCT,
  parameter logic [7:0] CROW_RST_PCT  = `TBPS_CROW_RST_PCT
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control link
  tbps_ctl_if.mon   ctl
);
  logic in_range_r;
  logic crow_r;

  // Thresholds scaled from the target, in millivolts times 100
  wire [19:0] fb_x100   = 20'(ctl.fb_mv) * 20'h64;
  wire [19:0] lo_lim    = 20'(ctl.target_mv) * 20'(PG_LOW_PCT);
  wire [19:0] hi_lim    = 20'(ctl.target_mv) * 20'(PG_HIGH_PCT);
  wire [19:0] crow_trip = 20'(ctl.target_mv) * 20'(CROW_TRIP_PCT);
  wire [19:0] crow_rel  = 20'(ctl.target_mv) * 20'(CROW_RST_PCT);
  wire        in_win    = (fb_x100 >= lo_lim) && (fb_x100 <= hi_lim);

  // Window flag and crowbar latch with release hysteresis
  always_ff @(posedge clk) begin
    if (rst) begin
      in_range_r <= 1'b0;
      crow_r     <= 1'b0;
    end else begin
      in_range_r <= in_win;
      if (fb_x100 >= crow_trip)
        crow_r <= 1'b1;
      else if (fb_x100 < crow_rel)
        crow_r <= 1'b0;
    end
  end

  assign ctl.in_range = in_range_r;
  assign ctl.crowbar  = crow_r;
endmodule // tbps_mon

// ---- hdl/tbps_core.sv ----
// Two-phase buck steering core: target decode, phase steering, foldback
`include "tbps_map.svh"
module tbps_core #(
  parameter int unsigned OSC_CYCLES    = `TBPS_OSC_CYCLES,
  parameter logic [11:0] FOLD_TRIG_MV  = `TBPS_FOLD_TRIG_MV,
  parameter logic [11:0] ZERO_MV       = `TBPS_ZERO_MV
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // Pin inputs from outside the clock domain
  input  wire logic [3:0]  VOLTAGE_SELECT_CODE,
  input  wire logic        CURRENT_TRIP,
  input  wire logic        COMP_DISABLE,
  // Feedback sample word, same clock
  input  wire logic [11:0] FEEDBACK_SENSE_MV,
  // Phase drive outputs
  output logic             PHASE_ONE_DRIVE,
  output logic             PHASE_TWO_DRIVE,
  // Open-drain in-range output
  output logic             OUTPUT_IN_RANGE_O,
  output logic             OUTPUT_IN_RANGE_OE,
  // Status outputs
  output logic             FOLDBACK_SENSE_SELECT,
  output logic             CROWBAR_ACTIVE,
  output logic [11:0]      TARGET_MV,
  output logic [11:0]      TIMING_RAMP_MV
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  // Reset pattern of the synchronisers as a named vector, so it can be indexed
  localparam logic [NSYNC-1:0] SYNC_RST = `TBPS_SYNC_RST;

  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  wire  [NSYNC-1:0] raw_in = {COMP_DISABLE, CURRENT_TRIP, VOLTAGE_SELECT_CODE};

  // Two flops per pin; select inputs reset to ones as if left open
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          meta_r[gi] <= SYNC_RST[gi];
          sync_r[gi] <= SYNC_RST[gi];
        end else begin
          meta_r[gi] <= raw_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  wire [3:0] vsel_s  = sync_r[3:0];
  wire       trip_s  = sync_r[4];
  wire       dis_s   = sync_r[5];

  // ----------------------------------------------------------------
  // Target decode and feedback register
  // ----------------------------------------------------------------
  logic [11:0] target_r;
  logic [11:0] fb_r;
  logic        fold_r;

  wire [3:0]  steps_up   = ~vsel_s; // Inverted at four bits before widening
  wire [11:0] target_nxt = `TBPS_TARGET_BASE_MV
                         + 12'(steps_up) * `TBPS_TARGET_STEP_MV;
  wire        fb_low     = (fb_r < FOLD_TRIG_MV);
  wire        fb_zero    = (fb_r <= ZERO_MV);

  // Decoded target, sampled feedback and threshold select
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      target_r <= `TBPS_TARGET_BASE_MV;
      fb_r     <= 12'h000;
      fold_r   <= 1'b0;
    end else begin
      target_r <= target_nxt;
      fb_r     <= FEEDBACK_SENSE_MV;
      fold_r   <= fb_low;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and monitor
  // ----------------------------------------------------------------
  tbps_ctl_if ctl ();

  assign ctl.run       = !dis_s;
  assign ctl.slow      = fb_zero;
  assign ctl.target_mv = target_r;
  assign ctl.fb_mv     = fb_r;

  tbps_osc #(
    .OSC_CYCLES (OSC_CYCLES)
  ) u_osc (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .ctl (ctl.osc)
  );

  tbps_mon u_mon (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .ctl (ctl.mon)
  );

  // ----------------------------------------------------------------
  // Phase steering
  // ----------------------------------------------------------------
  tbps_pkg::tbps_state_t state_r;
  tbps_pkg::tbps_state_t state_nxt;

  wire evt   = ctl.cycle_evt;
  wire halt  = ctl.crowbar || dis_s;

  // Next state: event sets the pointed phase, trip ends it
  always_comb begin
    state_nxt = state_r;
    if (halt) begin
      state_nxt = tbps_pkg::ST_HALT;
    end else begin
      case (state_r)
        tbps_pkg::ST_WAIT1: begin
          if (evt)
            state_nxt = tbps_pkg::ST_ON1;
        end
        tbps_pkg::ST_ON1: begin
          if (evt)
            state_nxt = tbps_pkg::ST_ON2;
          else if (trip_s)
            state_nxt = tbps_pkg::ST_WAIT2;
        end
        tbps_pkg::ST_WAIT2: begin
          if (evt)
            state_nxt = tbps_pkg::ST_ON2;
        end
        tbps_pkg::ST_ON2: begin
          if (evt)
            state_nxt = tbps_pkg::ST_ON1;
          else if (trip_s)
            state_nxt = tbps_pkg::ST_WAIT1;
        end
        tbps_pkg::ST_HALT: begin
          state_nxt = tbps_pkg::ST_WAIT1;
        end
        default: begin
          state_nxt = tbps_pkg::ST_WAIT1;
        end
      endcase
    end
  end

  // State register, phase one next after reset
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST)
      state_r <= tbps_pkg::ST_WAIT1;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One state bit per phase, so both can never be high at once
  assign PHASE_ONE_DRIVE       = (state_r == tbps_pkg::ST_ON1);
  assign PHASE_TWO_DRIVE       = (state_r == tbps_pkg::ST_ON2);
  assign OUTPUT_IN_RANGE_O     = 1'b0;
  assign OUTPUT_IN_RANGE_OE    = !ctl.in_range;
  assign FOLDBACK_SENSE_SELECT = fold_r;
  assign CROWBAR_ACTIVE        = ctl.crowbar;
  assign TARGET_MV             = target_r;
  assign TIMING_RAMP_MV        = ctl.ramp_mv;
endmodule // tbps_core

// ---- bench/tbps_drv_model.sv ----
// Behavioural model of one external half-bridge driver
module tbps_drv_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Phase input and switch states
  input  wire logic phase_in,
  output logic      high_on,
  output logic      low_on
);
  logic was_on_r;
  // High side follows the input, low side takes over after a fall
  assign high_on = phase_in;
  assign low_on  = !phase_in && was_on_r;
  // Remembers that the high side has been on
  always_ff @(posedge clk) begin
    if (rst) begin
      was_on_r <= 1'b0;
    end else if (phase_in) begin
      was_on_r <= 1'b1;
    end
  end
endmodule // tbps_drv_model

// ---- bench/tbps_core_props.sv ----
// Port checker of the steering core
module tbps_core_props #(
  parameter int unsigned OSC_CYCLES   = 50,
  parameter logic [11:0] FOLD_TRIG_MV = 12'h258
) (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Pin inputs
  input wire logic [3:0]  VOLTAGE_SELECT_CODE,
  input wire logic        CURRENT_TRIP,
  input wire logic        COMP_DISABLE,
  input wire logic [11:0] FEEDBACK_SENSE_MV,
  // Outputs under check
  input wire logic        PHASE_ONE_DRIVE,
  input wire logic        PHASE_TWO_DRIVE,
  input wire logic        OUTPUT_IN_RANGE_OE,
  input wire logic        FOLDBACK_SENSE_SELECT,
  input wire logic        CROWBAR_ACTIVE,
  input wire logic [11:0] TARGET_MV,
  input wire logic [11:0] TIMING_RAMP_MV
);
  localparam int MAX_ON = 5 * OSC_CYCLES;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Window compares in percent of the target
  wire logic [19:0] fb_x100 = 20'(FEEDBACK_SENSE_MV) * 20'h64;
  wire logic in_win  = fb_x100 >= 20'(TARGET_MV) * 20'h58 && fb_x100 <= 20'(TARGET_MV) * 20'h7c;
  wire logic crow_hi = fb_x100 >= 20'(TARGET_MV) * 20'h82;
  wire logic crow_lo = fb_x100 < 20'(TARGET_MV) * 20'h64;
  wire logic any_on  = PHASE_ONE_DRIVE || PHASE_TWO_DRIVE;
  wire logic [11:0] tgt_exp = 12'h514 + 12'(4'hf - VOLTAGE_SELECT_CODE) * 12'h032;
  logic        last_one_r;
  logic [15:0] on_cnt_r;
  // Last phase raised, cleared by halts; length of a phase-one on-time
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || CROWBAR_ACTIVE || COMP_DISABLE) last_one_r <= 1'b0;
    else if (PHASE_ONE_DRIVE) last_one_r <= 1'b1;
    else if (PHASE_TWO_DRIVE) last_one_r <= 1'b0;
    on_cnt_r <= (SYS_RST || !PHASE_ONE_DRIVE) ? 16'h0000 : on_cnt_r + 16'h0001;
  end
  sequence s_fb_steady;
    ($stable(FEEDBACK_SENSE_MV) && $stable(TARGET_MV)) [*4];
  endsequence
  sequence s_trip_one;
    PHASE_ONE_DRIVE && $rose(CURRENT_TRIP);
  endsequence
  a_reset_clear: assert property (disable iff (1'b0) SYS_RST [*2] |-> !any_on &&
    OUTPUT_IN_RANGE_OE && TARGET_MV == 12'h514 && TIMING_RAMP_MV == 12'h000)
    else $error("outputs not cleared by reset");
  a_never_both: assert property (!(PHASE_ONE_DRIVE && PHASE_TWO_DRIVE))
    else $error("both phases high");
  a_target_code: assert property ($stable(VOLTAGE_SELECT_CODE) [*5] |-> TARGET_MV == tgt_exp)
    else $error("target does not match code");
  a_fold_select: assert property ((!SYS_RST && $stable(FEEDBACK_SENSE_MV)) [*3] |->
    FOLDBACK_SENSE_SELECT == (FEEDBACK_SENSE_MV < FOLD_TRIG_MV)) else $error("fold select wrong");
  a_range_flag: assert property (s_fb_steady |-> OUTPUT_IN_RANGE_OE == !in_win)
    else $error("in-range flag wrong");
  a_crow_latch: assert property (s_fb_steady |->
    (!crow_hi || CROWBAR_ACTIVE) && (!crow_lo || !CROWBAR_ACTIVE)) else $error("crowbar latch wrong");
  a_crow_halt: assert property (CROWBAR_ACTIVE [*2] |-> !any_on)
    else $error("phase on during crowbar");
  a_disable_halt: assert property (COMP_DISABLE [*5] |-> !any_on && TIMING_RAMP_MV == 12'h000)
    else $error("phase or ramp running while disabled");
  a_trip_clear: assert property (s_trip_one |-> ##[1:4] !PHASE_ONE_DRIVE)
    else $error("trip did not end phase one");
  a_strict_alt: assert property ($rose(PHASE_ONE_DRIVE) || $rose(PHASE_TWO_DRIVE) |->
    last_one_r == PHASE_TWO_DRIVE) else $error("phases out of order");
  a_duty_bound: assert property (on_cnt_r <= MAX_ON)
    else $error("phase one on too long");
endmodule // tbps_core_props

bind tbps_core tbps_core_props #(.OSC_CYCLES(OSC_CYCLES), .FOLD_TRIG_MV(FOLD_TRIG_MV)) u_props (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .VOLTAGE_SELECT_CODE(VOLTAGE_SELECT_CODE),
  .CURRENT_TRIP(CURRENT_TRIP), .COMP_DISABLE(COMP_DISABLE), .FEEDBACK_SENSE_MV(FEEDBACK_SENSE_MV),
  .PHASE_ONE_DRIVE(PHASE_ONE_DRIVE), .PHASE_TWO_DRIVE(PHASE_TWO_DRIVE),
  .OUTPUT_IN_RANGE_OE(OUTPUT_IN_RANGE_OE), .FOLDBACK_SENSE_SELECT(FOLDBACK_SENSE_SELECT),
  .CROWBAR_ACTIVE(CROWBAR_ACTIVE), .TARGET_MV(TARGET_MV), .TIMING_RAMP_MV(TIMING_RAMP_MV));

// ---- bench/test_two_phase_buck_pwm_steering.sv ----
// Self-checking bench of the two-phase steering core
module test_two_phase_buck_pwm_steering;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned OSC = 10;
  // Stimulus and observed signals
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [3:0]  vsel = 4'hf;
  logic        trip = 1'b0;
  logic        dis  = 1'b0;
  logic [11:0] fb   = 12'h514;
  logic        p1, p2, rng_o, rng_oe, fold, crow, hs1, ls1, hs2, ls2;
  logic [11:0] tgt, ramp;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  int          a, b;
  // Core under test and the two driver models
  tbps_core #(.OSC_CYCLES(OSC)) uut (.REF_CLK(clk), .SYS_RST(rst), .VOLTAGE_SELECT_CODE(vsel),
    .CURRENT_TRIP(trip), .COMP_DISABLE(dis), .FEEDBACK_SENSE_MV(fb), .PHASE_ONE_DRIVE(p1),
    .PHASE_TWO_DRIVE(p2), .OUTPUT_IN_RANGE_O(rng_o), .OUTPUT_IN_RANGE_OE(rng_oe),
    .FOLDBACK_SENSE_SELECT(fold), .CROWBAR_ACTIVE(crow), .TARGET_MV(tgt), .TIMING_RAMP_MV(ramp));
  tbps_drv_model drv1 (.clk(clk), .rst(rst), .phase_in(p1), .high_on(hs1), .low_on(ls1));
  tbps_drv_model drv2 (.clk(clk), .rst(rst), .phase_in(p2), .high_on(hs2), .low_on(ls2));
  // Clock and cycle stamp
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic conclude();
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for a rise of one phase and stamps its cycle
  task automatic wait_up(input bit two, output int at);
    logic prev;
    prev = two ? p2 : p1;
    for (int n = 0; n < 1500; n++) begin
      @(negedge clk);
      at = cyc;
      if ((two ? p2 : p1) === 1'b1 && prev !== 1'b1) return;
      prev = two ? p2 : p1;
    end
    fails++;
    conclude();
  endtask
  task automatic pulse_trip();
    @(posedge clk);
    trip <= 1'b1;
    repeat (2) @(posedge clk);
    trip <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic drive_fb(input logic [11:0] v);
    @(posedge clk);
    fb <= v;
    repeat (5) @(negedge clk);
  endtask
  task automatic t_steer();
    wait_up(1'b0, a);
    check(p2, 1'b0);
    check(hs1, 1'b1);
    pulse_trip();
    check(p1, 1'b0);
    check(ls1, 1'b1);
    wait_up(1'b1, b);
    check(12'(b - a), 12'(OSC));
    pulse_trip();
    check(p2, 1'b0);
    check(ls2, 1'b1);
    wait_up(1'b0, a);
    check(12'(a - b), 12'(OSC));
    wait_up(1'b1, b);
    check(p1, 1'b0);
    check(12'(b - a), 12'(OSC));
  endtask
  task automatic t_target();
    for (logic [4:0] c = 5'h00; c < 5'h10; c++) begin
      @(posedge clk);
      vsel <= c[3:0];
      repeat (6) @(negedge clk);
      check(tgt, 12'h514 + 12'(5'h0f - c) * 12'h032);
    end
    @(posedge clk);
    vsel <= 4'hf;
    repeat (5) @(negedge clk);
  endtask
  task automatic t_fold();
    drive_fb(12'h257);
    check(fold, 1'b1);
    drive_fb(12'h258);
    check(fold, 1'b0);
    drive_fb(12'h000);
    check(rng_oe, 1'b1);
    wait_up(1'b0, a);
    wait_up(1'b1, a);
    wait_up(1'b0, b);
    check(12'(b - a), 12'(5 * OSC));
    drive_fb(12'h514);
  endtask
  task automatic t_range();
    logic [11:0] v [4] = '{12'h478, 12'h477, 12'h64c, 12'h64d};
    logic        e [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      drive_fb(v[i]);
      check(rng_oe, e[i]);
    end
    drive_fb(12'h69a);
    check(crow, 1'b1);
    repeat (2 * OSC) @(negedge clk);
    check(p1 | p2, 1'b0);
    drive_fb(12'h514);
    check(crow, 1'b1);
    drive_fb(12'h513);
    check(crow, 1'b0);
    wait_up(1'b0, a);
    drive_fb(12'h514);
  endtask
  task automatic t_disable();
    @(posedge clk);
    dis <= 1'b1;
    repeat (3 * OSC) @(negedge clk);
    check(p1 | p2, 1'b0);
    check(ramp, 12'h000);
    check(tgt, 12'h514);
    @(posedge clk);
    dis <= 1'b0;
    wait_up(1'b0, a);
    check(p2, 1'b0);
  endtask
  // Mid-run reset with the select pins at all zeros
  task automatic t_reset();
    @(posedge clk);
    rst  <= 1'b1;
    vsel <= 4'h0;
    repeat (4) @(negedge clk);
    check(p1 | p2, 1'b0);
    check(tgt, 12'h514);
    check(rng_oe, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check(tgt, 12'h514);
    repeat (2) @(negedge clk);
    check(tgt, 12'h802);
    wait_up(1'b0, a);
    check(p2, 1'b0);
    check(rng_oe, 1'b1);
    check(rng_o, 1'b0);
    @(posedge clk);
    vsel <= 4'hf;
    repeat (5) @(negedge clk);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_steer();
    t_target();
    t_fold();
    t_range();
    t_disable();
    t_reset();
    conclude();
  end
endmodule // test_two_phase_buck_pwm_steering
